/* core/adc_result_computation.sv */
// Operation
// [R1] A three-bit control field picks one of five computation modes.
// [R2] Basic mode converts once, or twice when double sampling is enabled.
// [R3] Basic mode raises conversion-done only after all requested conversions finish.
// [R4] Accumulate mode adds each triggered result into accumulator and bumps tally.
// [R5] Accumulate mode flags done per conversion and tests threshold per calculation.
// [R6] Average mode accumulates per trigger and tests once repeat target is reached.
// [R7] Average mode clears accumulator on trigger after a test, needing fresh samples.
// [R8] Burst mode clears on trigger, converts repeatedly to repeat target, then tests.
// [R9] Low-pass mode filters each result, first test after repeat target samples.
// [R10] Low-pass mode tests again on every trigger after the first test.
// [R11] Sixteen-bit setpoint lives in two byte registers, both reset to zero.
// [R12] Calculation select decides whether setpoint enters the error value.
// [R13] Each test compares error with thresholds and sets threshold flag on a hit.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module adc_result_computation (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire adc_compute_pkg::bus_req_s busReq,
  output logic [7:0] regRdata,
  // Converter core
  input wire logic trigger,
  input wire logic convDone,
  input wire logic [15:0] convResult,
  output logic convReq,
  // Flags
  output logic conversionDoneFlag,
  output logic thresholdFlag
);

  logic [1:0] rstPipe_ff;
  logic rstSync;
  adc_compute_pkg::core_s core_ff;
  adc_compute_pkg::core_s nxt_core;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rstPipe_ff <= 2'b00;
    else
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
  end

  assign rstSync = rstPipe_ff[1];

  always_comb
  begin
    logic [23:0] sumAcc;
    logic [23:0] newAcc;
    logic [23:0] shifted;
    logic [15:0] filtVal;
    logic signed [16:0] err;
    logic signed [16:0] upperS;
    logic signed [16:0] lowerS;
    logic [7:0] tallyInc;
    logic reached;
    logic hit;
    logic setDone;
    logic doTest;
    logic clrDone;
    logic clrThr;
    sumAcc = (core_ff.computeModeSelect == adc_compute_pkg::MODE_LOWPASS) ?
             core_ff.acc - (core_ff.acc >> core_ff.avgShift) : core_ff.acc;
    newAcc = sumAcc + {8'h00, convResult};
    shifted = newAcc >> core_ff.avgShift;
    filtVal = shifted[15:0];
    err = core_ff.calculationSelect ? $signed({1'b0, filtVal}) :
          $signed({1'b0, filtVal}) - $signed({1'b0, core_ff.thresholdSetpoint}); // [R12]
    upperS = $signed({core_ff.upperThreshold[15], core_ff.upperThreshold});
    lowerS = $signed({core_ff.lowerThreshold[15], core_ff.lowerThreshold});
    case (core_ff.testCond) // [R13]
      adc_compute_pkg::COND_BELOW_LOWER: hit = err < lowerS;
      adc_compute_pkg::COND_ATLEAST_LOWER: hit = err >= lowerS;
      adc_compute_pkg::COND_ABOVE_UPPER: hit = err > upperS;
      adc_compute_pkg::COND_ATMOST_UPPER: hit = err <= upperS;
      adc_compute_pkg::COND_OUTSIDE: hit = (err < lowerS) || (err > upperS);
      adc_compute_pkg::COND_INSIDE: hit = (err >= lowerS) && (err <= upperS);
      adc_compute_pkg::COND_ALWAYS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    tallyInc = (core_ff.sampleTally == adc_compute_pkg::TALLY_MAX) ? core_ff.sampleTally :
               core_ff.sampleTally + 8'h01;
    reached = tallyInc >= core_ff.repeatTarget;
    nxt_core = core_ff;
    nxt_core.convReq = 1'b0;
    nxt_core.testStrobe = 1'b0;
    nxt_core.testHit = 1'b0;
    nxt_core.rdata = adc_compute_pkg::RESET_BYTE;
    setDone = 1'b0;
    doTest = 1'b0;
    clrDone = 1'b0;
    clrThr = 1'b0;

    // Register writes.
    if (busReq.wr)
    begin
      if (busReq.addr == adc_compute_pkg::ADDR_CONTROL)
      begin
        nxt_core.computeModeSelect = busReq.wdata[adc_compute_pkg::MODE_LSB +: 3]; // [R1]
        nxt_core.doubleSampleEnable = busReq.wdata[adc_compute_pkg::DOUBLE_BIT];
        nxt_core.calculationSelect = busReq.wdata[adc_compute_pkg::CALC_BIT];
      end
      else if (busReq.addr == adc_compute_pkg::ADDR_TEST_CFG)
      begin
        nxt_core.testCond = busReq.wdata[adc_compute_pkg::COND_LSB +: 3];
        nxt_core.avgShift = busReq.wdata[adc_compute_pkg::SHIFT_LSB +: 3];
      end
      else if (busReq.addr == adc_compute_pkg::ADDR_REPEAT)
        nxt_core.repeatTarget = busReq.wdata;
      else if (busReq.addr == adc_compute_pkg::ADDR_SETPOINT_HIGH)
        nxt_core.thresholdSetpoint[15:8] = busReq.wdata; // [R11]
      else if (busReq.addr == adc_compute_pkg::ADDR_SETPOINT_LOW)
        nxt_core.thresholdSetpoint[7:0] = busReq.wdata; // [R11]
      else if (busReq.addr == adc_compute_pkg::ADDR_UPPER_HIGH)
        nxt_core.upperThreshold[15:8] = busReq.wdata;
      else if (busReq.addr == adc_compute_pkg::ADDR_UPPER_LOW)
        nxt_core.upperThreshold[7:0] = busReq.wdata;
      else if (busReq.addr == adc_compute_pkg::ADDR_LOWER_HIGH)
        nxt_core.lowerThreshold[15:8] = busReq.wdata;
      else if (busReq.addr == adc_compute_pkg::ADDR_LOWER_LOW)
        nxt_core.lowerThreshold[7:0] = busReq.wdata;
      else if (busReq.addr == adc_compute_pkg::ADDR_STATUS)
      begin
        clrDone = busReq.wdata[adc_compute_pkg::DONE_BIT];
        clrThr = busReq.wdata[adc_compute_pkg::THR_BIT];
      end
    end

    // Register reads; data appear in the next cycle only.
    if (busReq.rd)
    begin
      if (busReq.addr == adc_compute_pkg::ADDR_CONTROL)
        nxt_core.rdata = {3'b000, core_ff.calculationSelect, core_ff.doubleSampleEnable,
                          core_ff.computeModeSelect};
      else if (busReq.addr == adc_compute_pkg::ADDR_TEST_CFG)
        nxt_core.rdata = {1'b0, core_ff.avgShift, 1'b0, core_ff.testCond};
      else if (busReq.addr == adc_compute_pkg::ADDR_REPEAT)
        nxt_core.rdata = core_ff.repeatTarget;
      else if (busReq.addr == adc_compute_pkg::ADDR_SETPOINT_HIGH)
        nxt_core.rdata = core_ff.thresholdSetpoint[15:8];
      else if (busReq.addr == adc_compute_pkg::ADDR_SETPOINT_LOW)
        nxt_core.rdata = core_ff.thresholdSetpoint[7:0];
      else if (busReq.addr == adc_compute_pkg::ADDR_UPPER_HIGH)
        nxt_core.rdata = core_ff.upperThreshold[15:8];
      else if (busReq.addr == adc_compute_pkg::ADDR_UPPER_LOW)
        nxt_core.rdata = core_ff.upperThreshold[7:0];
      else if (busReq.addr == adc_compute_pkg::ADDR_LOWER_HIGH)
        nxt_core.rdata = core_ff.lowerThreshold[15:8];
      else if (busReq.addr == adc_compute_pkg::ADDR_LOWER_LOW)
        nxt_core.rdata = core_ff.lowerThreshold[7:0];
      else if (busReq.addr == adc_compute_pkg::ADDR_STATUS)
        nxt_core.rdata = {5'b00000, core_ff.phase == adc_compute_pkg::ST_WAIT,
                          core_ff.thresholdFlag, core_ff.conversionDoneFlag};
      else if (busReq.addr == adc_compute_pkg::ADDR_TALLY)
        nxt_core.rdata = core_ff.sampleTally;
      else if (busReq.addr == adc_compute_pkg::ADDR_ACC_LOW)
        nxt_core.rdata = core_ff.acc[7:0];
      else if (busReq.addr == adc_compute_pkg::ADDR_ACC_MID)
        nxt_core.rdata = core_ff.acc[15:8];
      else if (busReq.addr == adc_compute_pkg::ADDR_ACC_HIGH)
        nxt_core.rdata = core_ff.acc[23:16];
    end

    // Conversion sequencing.
    case (core_ff.phase)
      adc_compute_pkg::ST_IDLE:
      begin
        if (trigger)
        begin
          nxt_core.phase = adc_compute_pkg::ST_WAIT;
          nxt_core.convReq = 1'b1;
          nxt_core.convsLeft = core_ff.doubleSampleEnable ? 2'd2 : 2'd1; // [R2]
          if (core_ff.computeModeSelect == adc_compute_pkg::MODE_BURST ||
              (core_ff.computeModeSelect == adc_compute_pkg::MODE_AVERAGE &&
               core_ff.clearPending))
          begin
            nxt_core.acc = 24'h00_0000; // [R7] [R8]
            nxt_core.sampleTally = adc_compute_pkg::RESET_BYTE;
            nxt_core.clearPending = 1'b0;
          end
        end
      end
      adc_compute_pkg::ST_WAIT:
      begin
        if (convDone)
        begin
          nxt_core.phase = adc_compute_pkg::ST_IDLE;
          case (core_ff.computeModeSelect)
            adc_compute_pkg::MODE_ACCUMULATE:
            begin
              nxt_core.acc = newAcc; // [R4]
              nxt_core.sampleTally = tallyInc;
              setDone = 1'b1; // [R5]
              doTest = 1'b1;
            end
            adc_compute_pkg::MODE_AVERAGE:
            begin
              nxt_core.acc = newAcc;
              nxt_core.sampleTally = tallyInc;
              setDone = 1'b1;
              doTest = reached; // [R6]
              nxt_core.clearPending = reached; // [R7]
            end
            adc_compute_pkg::MODE_BURST:
            begin
              nxt_core.acc = newAcc;
              nxt_core.sampleTally = tallyInc;
              if (reached)
              begin
                setDone = 1'b1;
                doTest = 1'b1; // [R8]
              end
              else
              begin
                nxt_core.phase = adc_compute_pkg::ST_WAIT;
                nxt_core.convReq = 1'b1; // [R8]
              end
            end
            adc_compute_pkg::MODE_LOWPASS:
            begin
              nxt_core.acc = newAcc; // [R9]
              nxt_core.sampleTally = tallyInc;
              setDone = 1'b1;
              doTest = reached; // [R9] [R10]
            end
            default:
            begin
              nxt_core.lastSample = convResult;
              if (core_ff.convsLeft > 2'd1)
              begin
                nxt_core.convsLeft = core_ff.convsLeft - 2'd1;
                nxt_core.phase = adc_compute_pkg::ST_WAIT;
                nxt_core.convReq = 1'b1;
              end
              else
                setDone = 1'b1; // [R3]
            end
          endcase
        end
      end
      default: nxt_core.phase = adc_compute_pkg::ST_IDLE;
    endcase

    // A hardware set in the same cycle as a software clear wins.
    nxt_core.testStrobe = doTest;
    nxt_core.testHit = doTest && hit;
    nxt_core.conversionDoneFlag = (core_ff.conversionDoneFlag && !clrDone) || setDone;
    nxt_core.thresholdFlag = (core_ff.thresholdFlag && !clrThr) || (doTest && hit); // [R13]
  end

  always_ff @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      core_ff <= '0;
      core_ff.phase <= adc_compute_pkg::ST_IDLE;
    end
    else
    begin
      core_ff <= nxt_core;
    end
  end

  assign regRdata = core_ff.rdata;
  assign convReq = core_ff.convReq;
  assign conversionDoneFlag = core_ff.conversionDoneFlag;
  assign thresholdFlag = core_ff.thresholdFlag;

  AST_MODE_WRITE: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R1]
    busReq.wr && busReq.addr == adc_compute_pkg::ADDR_CONTROL
    |=> core_ff.computeModeSelect == $past(busReq.wdata[2:0]))
    else $error("Mode field did not follow control write.");

  AST_DOUBLE_COUNT: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R2]
    core_ff.phase == adc_compute_pkg::ST_IDLE && trigger && core_ff.doubleSampleEnable
    |=> core_ff.convsLeft == 2'd2 && convReq)
    else $error("Double sampling did not schedule two conversions.");

  AST_BASIC_DONE_LATE: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R3]
    core_ff.phase == adc_compute_pkg::ST_WAIT && convDone && core_ff.convsLeft == 2'd2 &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_BASIC
    |=> convReq && conversionDoneFlag == $past(conversionDoneFlag))
    else $error("Basic mode flagged done before its last conversion.");

  AST_ACC_SUM: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R4]
    core_ff.phase == adc_compute_pkg::ST_WAIT && convDone &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_ACCUMULATE
    |=> core_ff.acc == $past(core_ff.acc) + {8'h00, $past(convResult)} &&
        core_ff.sampleTally != $past(core_ff.sampleTally) || $past(core_ff.sampleTally) == 8'hFF)
    else $error("Accumulate mode did not add the result.");

  AST_ACC_DONE: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R5]
    core_ff.phase == adc_compute_pkg::ST_WAIT && convDone &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_ACCUMULATE
    |=> conversionDoneFlag && core_ff.testStrobe)
    else $error("Accumulate mode missed done flag or test.");

  AST_AVG_TEST: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R6]
    core_ff.phase == adc_compute_pkg::ST_WAIT && convDone &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_AVERAGE
    |=> core_ff.testStrobe == (core_ff.sampleTally >= core_ff.repeatTarget))
    else $error("Average mode test not tied to repeat target.");

  AST_AVG_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R7]
    core_ff.phase == adc_compute_pkg::ST_IDLE && trigger && core_ff.clearPending &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_AVERAGE
    |=> core_ff.acc == 24'h00_0000 && core_ff.sampleTally == 8'h00)
    else $error("Average mode did not clear after a test.");

  AST_BURST_RUN: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R8]
    core_ff.phase == adc_compute_pkg::ST_WAIT && convDone &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_BURST &&
    {1'b0, core_ff.sampleTally} + 9'h001 < {1'b0, core_ff.repeatTarget}
    |=> convReq && !core_ff.testStrobe)
    else $error("Burst mode stopped early.");

  AST_LPF_TEST: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R9] [R10]
    core_ff.phase == adc_compute_pkg::ST_WAIT && convDone &&
    core_ff.computeModeSelect == adc_compute_pkg::MODE_LOWPASS &&
    core_ff.sampleTally >= core_ff.repeatTarget
    |=> core_ff.testStrobe)
    else $error("Low-pass mode skipped a test.");

  AST_SETPOINT_HIGH: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R11]
    busReq.wr && busReq.addr == adc_compute_pkg::ADDR_SETPOINT_HIGH
    |=> core_ff.thresholdSetpoint[15:8] == $past(busReq.wdata))
    else $error("Setpoint high byte not stored.");

  AST_THR_FLAG: assert property (@(posedge sys_clk) disable iff (!rstSync) // [R13]
    core_ff.testHit |-> thresholdFlag ##1 (thresholdFlag || $past(busReq.wr)))
    else $error("Threshold hit did not set the flag.");

endmodule : adc_result_computation

/* core/adc_compute_pkg.sv */
package adc_compute_pkg;

  // Register indices on the byte-wide register port.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TEST_CFG = 4'h1;
  localparam logic [3:0] ADDR_REPEAT = 4'h2;
  localparam logic [3:0] ADDR_SETPOINT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_SETPOINT_LOW = 4'h4;
  localparam logic [3:0] ADDR_UPPER_HIGH = 4'h5;
  localparam logic [3:0] ADDR_UPPER_LOW = 4'h6;
  localparam logic [3:0] ADDR_LOWER_HIGH = 4'h7;
  localparam logic [3:0] ADDR_LOWER_LOW = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'h9;
  localparam logic [3:0] ADDR_TALLY = 4'hA;
  localparam logic [3:0] ADDR_ACC_LOW = 4'hB;
  localparam logic [3:0] ADDR_ACC_MID = 4'hC;
  localparam logic [3:0] ADDR_ACC_HIGH = 4'hD;

  // Field positions.
  localparam int MODE_LSB = 0;
  localparam int DOUBLE_BIT = 3;
  localparam int CALC_BIT = 4;
  localparam int COND_LSB = 0;
  localparam int SHIFT_LSB = 4;
  localparam int DONE_BIT = 0;
  localparam int THR_BIT = 1;
  localparam int BUSY_BIT = 2;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Computation modes.
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUMULATE = 3'h1;
  localparam logic [2:0] MODE_AVERAGE = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LOWPASS = 3'h4;

  // Threshold conditions.
  localparam logic [2:0] COND_NEVER = 3'h0;
  localparam logic [2:0] COND_BELOW_LOWER = 3'h1;
  localparam logic [2:0] COND_ATLEAST_LOWER = 3'h2;
  localparam logic [2:0] COND_ABOVE_UPPER = 3'h3;
  localparam logic [2:0] COND_ATMOST_UPPER = 3'h4;
  localparam logic [2:0] COND_OUTSIDE = 3'h5;
  localparam logic [2:0] COND_INSIDE = 3'h6;
  localparam logic [2:0] COND_ALWAYS = 3'h7;

  localparam logic [7:0] TALLY_MAX = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } phase_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    phase_e phase;
    logic [2:0] computeModeSelect;
    logic doubleSampleEnable;
    logic calculationSelect;
    logic [2:0] testCond;
    logic [2:0] avgShift;
    logic [7:0] repeatTarget;
    logic [15:0] thresholdSetpoint;
    logic [15:0] upperThreshold;
    logic [15:0] lowerThreshold;
    logic conversionDoneFlag;
    logic thresholdFlag;
    logic [7:0] sampleTally;
    logic [23:0] acc;
    logic [15:0] lastSample;
    logic [1:0] convsLeft;
    logic clearPending;
    logic convReq;
    logic [7:0] rdata;
    logic testStrobe;
    logic testHit;
  } core_s;

endpackage : adc_compute_pkg

/* testbench/adc_conv_model.sv */
`timescale 1ns/100ps
module adc_conv_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Request side
  input wire logic convReq,
  input wire logic [3:0] latency,
  input wire logic [15:0] sampleVal,
  // Result side
  output logic convDone,
  output logic [15:0] convResult
);
  logic [3:0] waitCnt;

  // One result per request, latency cycles later; the bus toggles while no result stands.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      waitCnt <= 4'h0;
      convDone <= 1'b0;
      convResult <= 16'hA5A5;
    end
    else
    begin
      convDone <= 1'b0;
      convResult <= ~convResult;
      if (convReq)
        waitCnt <= latency;
      else if (waitCnt != 4'h0)
        waitCnt <= waitCnt - 4'h1;
      if (waitCnt == 4'h1)
      begin
        convDone <= 1'b1;
        convResult <= sampleVal;
      end
    end
  end
endmodule : adc_conv_model

/* testbench/adc_result_computation_tb.sv */
`timescale 1ns/100ps
module adc_result_computation_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  adc_compute_pkg::bus_req_s busReq = '0;
  logic [7:0] regRdata;
  logic trigger = 1'b0;
  logic convDone;
  logic convReq;
  logic conversionDoneFlag;
  logic thresholdFlag;
  logic [15:0] convResult;
  logic [15:0] sampleVal = 16'h0000;
  logic [3:0] lat = 4'h1;
  logic [7:0] rd;
  logic midFlag;
  int failCount = 0;
  int checksDone = 0;
  int nReq;

  always #12.5 sys_clk = ~sys_clk;

  adc_result_computation i_dut (.sys_clk(sys_clk), .rstn(rstn), .busReq(busReq),
    .regRdata(regRdata), .trigger(trigger), .convDone(convDone), .convResult(convResult),
    .convReq(convReq), .conversionDoneFlag(conversionDoneFlag), .thresholdFlag(thresholdFlag));

  adc_conv_model i_conv (.sys_clk(sys_clk), .rstn(rstn), .convReq(convReq), .latency(lat),
    .sampleVal(sampleVal), .convDone(convDone), .convResult(convResult));

  task automatic printVerdict();
    $display("Checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : printVerdict

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic doReset();
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : doReset

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    busReq <= '0;
    @(posedge sys_clk);
  endtask : regWrite

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic readChk(input logic [3:0] a, input logic [7:0] exp, input string what);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    busReq <= '0;
    @(negedge sys_clk);
    rd = regRdata;
    @(posedge sys_clk);
    check(what, {8'h00, exp}, {8'h00, rd});
  endtask : readChk

  task automatic cfg(input logic [7:0] ctrl, input logic [7:0] tcfg, input logic [7:0] repeat_target);
    regWrite(adc_compute_pkg::ADDR_CONTROL, ctrl);
    regWrite(adc_compute_pkg::ADDR_TEST_CFG, tcfg);
    regWrite(adc_compute_pkg::ADDR_REPEAT, repeat_target);
  endtask : cfg

  task automatic clearFlags();
    regWrite(adc_compute_pkg::ADDR_STATUS, 8'h03);
  endtask : clearFlags

  // Triggers once and follows n conversions, then watches the cycle of the last done and three more cycles.
  task automatic fire(input logic [15:0] smp, input int n);
    int dones;
    int tail;
    dones = 0;
    tail = 0;
    nReq = 0;
    midFlag = 1'b0;
    sampleVal <= smp;
    trigger <= 1'b1;
    @(posedge sys_clk);
    trigger <= 1'b0;
    for (int i = 0; i < 300 && tail < 4; i++)
    begin
      #1;
      if (convReq === 1'b1) nReq++;
      if (dones == 1 && convDone !== 1'b1) midFlag = conversionDoneFlag;
      if (convDone === 1'b1) dones++;
      if (dones >= n) tail++;
      @(posedge sys_clk);
    end
    if (tail < 4)
    begin
      failCount++;
      $display("MISMATCH conversions expected %0d seen %0d", n, dones);
      printVerdict();
    end
    else
      check("convReq count", 16'(n), 16'(nReq));
  endtask : fire

  function automatic logic expHit(input logic [2:0] c, input int e);
    case (c)
      3'h1: return e < 0;
      3'h2: return e >= 0;
      3'h3: return e > 256;
      3'h4: return e <= 256;
      3'h5: return e < 0 || e > 256;
      3'h6: return e >= 0 && e <= 256;
      3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : expHit

  initial
  begin
    logic [15:0] smp;
    doReset();
    readChk(adc_compute_pkg::ADDR_SETPOINT_HIGH, 8'h00, "setpointHigh");
    readChk(adc_compute_pkg::ADDR_SETPOINT_LOW, 8'h00, "setpointLow");
    regWrite(adc_compute_pkg::ADDR_SETPOINT_HIGH, 8'hA5);
    regWrite(adc_compute_pkg::ADDR_SETPOINT_LOW, 8'h3C);
    readChk(adc_compute_pkg::ADDR_SETPOINT_HIGH, 8'hA5, "setpointHigh");
    readChk(adc_compute_pkg::ADDR_SETPOINT_LOW, 8'h3C, "setpointLow");
    regWrite(4'hF, 8'h77);
    readChk(4'hF, 8'h00, "unmapped");
    $display("Test registers done");

    // Accumulate mode, error taken as the value itself, test always hits.
    doReset();
    cfg(8'h11, 8'h07, 8'h01);
    for (int k = 1; k <= 3; k++)
    begin
      fire(16'(16 * k), 1);
      readChk(adc_compute_pkg::ADDR_TALLY, 8'(k), "tally");
      readChk(adc_compute_pkg::ADDR_ACC_LOW, 8'(8 * k * (k + 1)), "accLow");
      check("doneFlag", 16'h0001, {15'h0, conversionDoneFlag});
      check("thresholdFlag", 16'h0001, {15'h0, thresholdFlag});
      clearFlags();
    end
    $display("Test accumulate done");

    doReset();
    cfg(8'h00, 8'h07, 8'h01);
    fire(16'h0123, 1);
    check("doneFlag", 16'h0001, {15'h0, conversionDoneFlag});
    clearFlags();
    lat <= 4'h5;
    regWrite(adc_compute_pkg::ADDR_CONTROL, 8'h08);
    fire(16'h0123, 2);
    check("doneFlag early", 16'h0000, {15'h0, midFlag});
    check("doneFlag", 16'h0001, {15'h0, conversionDoneFlag});
    lat <= 4'h1;
    $display("Test basic done");

    // Single-sample bursts; error is value minus setpoint 0x0100, window 0..256.
    doReset();
    cfg(8'h03, 8'h00, 8'h01);
    regWrite(adc_compute_pkg::ADDR_SETPOINT_HIGH, 8'h01);
    regWrite(adc_compute_pkg::ADDR_UPPER_HIGH, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      for (int s = 0; s < 3; s++)
      begin
        smp = 16'h0050 + 16'(s * 256);
        regWrite(adc_compute_pkg::ADDR_TEST_CFG, 8'(c));
        clearFlags();
        fire(smp, 1);
        check("condHit", {15'h0, expHit(3'(c), int'(smp) - 256)}, {15'h0, thresholdFlag});
      end
    end
    $display("Test conditions done");

    doReset();
    cfg(8'h12, 8'h07, 8'h03);
    for (int k = 1; k <= 3; k++)
    begin
      fire(16'h0021, 1);
      check("thresholdFlag", {15'h0, k == 3}, {15'h0, thresholdFlag});
    end
    readChk(adc_compute_pkg::ADDR_ACC_LOW, 8'h63, "accLow");
    clearFlags();
    fire(16'h0005, 1);
    readChk(adc_compute_pkg::ADDR_ACC_LOW, 8'h05, "accLow");
    check("thresholdFlag", 16'h0000, {15'h0, thresholdFlag});
    $display("Test average done");

    doReset();
    cfg(8'h13, 8'h07, 8'h04);
    for (int k = 0; k < 2; k++)
    begin
      fire(16'h0011, 4);
      readChk(adc_compute_pkg::ADDR_ACC_LOW, 8'h44, "accLow");
      check("thresholdFlag", 16'h0001, {15'h0, thresholdFlag});
      clearFlags();
    end
    $display("Test burst done");

    // Low-pass with shift 1: 0x40, then 0x60, then 0x70.
    doReset();
    cfg(8'h14, 8'h17, 8'h02);
    fire(16'h0040, 1);
    check("thresholdFlag", 16'h0000, {15'h0, thresholdFlag});
    fire(16'h0040, 1);
    check("thresholdFlag", 16'h0001, {15'h0, thresholdFlag});
    readChk(adc_compute_pkg::ADDR_ACC_LOW, 8'h60, "accLow");
    clearFlags();
    fire(16'h0040, 1);
    check("thresholdFlag", 16'h0001, {15'h0, thresholdFlag});
    readChk(adc_compute_pkg::ADDR_ACC_LOW, 8'h70, "accLow");
    $display("Test lowpass done");
    printVerdict();
  end
endmodule : adc_result_computation_tb
